// ===== rtl/ccs_top.sv
// Purpose: charge phase, parameter and termination sequencing of a one-cell charger
// Assumes: analog comparators arrive as levels synchronous to ref_clk
// Notes: sys_rst is the supply power-on reset; por_event is the input-supply power-on
`timescale 1ns/1ps
`include "ccs_regs.svh"
// Functional notes
// - Short current below short threshold, ramp to fast charge, taper at regulation
// - Host mode with termination: stop PWM, sink detect current, then sample battery
// - Battery low after detect window: absent, defaults restored, retry after delay
// - After supply power-on, default mode until first host transaction
// - Host kicks before input power-on keep host mode, else defaults
// - Default input limit from limit-select pin, host limit in host mode
// - Factory mode follows its bit only while no battery is present
// - Factory mode: current amplifier off, high-side limit doubled, continuous conduction
// - Spread spectrum steps through eight offsets, four up, four down
// - Synchronous rectification only while low-side current exceeds threshold or factory mode is on
// - Duty cycle bounded between zero and the maximum
// - Regulation voltage fixed in default mode, host-programmable in range
// - Termination needs deglitched recharge level and termination current
// - Completion reported only after the synchronisation delay
// - Termination enable bit low disables current-based termination
// - New cycle on recharge, input power-on with low battery, enable toggle, reset
// - Thermal shutdown stops PWM and freezes all timers until recovered
// - Default mode keeps charging with reset values
module ccs_top #(
   parameter int T_DEGLITCH = `CCS_T_DEGLITCH_MS * `CCS_CLK_KHZ,
   parameter int T_DETECT = `CCS_T_DETECT_MS * `CCS_CLK_KHZ,
   parameter int T_SYNC = `CCS_T_SYNC_MS * `CCS_CLK_KHZ,
   parameter int T_RETRY = `CCS_T_RETRY_MS * `CCS_CLK_KHZ,
   parameter int T_SS_STEP = `CCS_T_SS_STEP_US * `CCS_CLK_KHZ / 1000,
   parameter int T_SLEW = `CCS_T_SLEW_US * `CCS_CLK_KHZ / 1000
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic por_event,
   input wire logic i2c_txn,
   input wire logic watchdog_kick_bit,
   input wire logic termination_enable_bit,
   input wire logic charge_disable_bit,
   input wire logic reset_bit,
   input wire logic factory_mode_bit,
   input wire logic spread_enable_bit,
   input wire logic limit_select_pin,
   input wire ccs_pkg::ccs_iin_t host_iin_limit,
   input wire logic [5:0] host_vreg_code,
   input wire logic [3:0] host_ichg_code,
   input wire logic batt_below_short,
   input wire logic batt_above_rch,
   input wire logic batt_below_lowv,
   input wire logic batt_at_vreg,
   input wire logic term_current_det,
   input wire logic lowside_above_thr,
   input wire logic no_battery,
   input wire logic over_temp,
   input wire logic temp_recovered,
   input wire logic [7:0] duty_req,
   output logic host_mode_q,
   output logic pwm_en_q,
   output logic short_mode_q,
   output logic cv_taper_q,
   output logic [3:0] chg_current_q,
   output logic detect_sink_q,
   output logic charge_done_q,
   output logic batt_absent_q,
   output logic stat_o_q,
   output logic stat_oe_q,
   output ccs_pkg::ccs_iin_t iin_limit_q,
   output logic [5:0] vreg_code_q,
   output logic ichg_amp_en_q,
   output logic hs_limit_x2_q,
   output logic continuous_conduction_q,
   output logic sync_rect_q,
   output logic [7:0] duty_q,
   output logic [3:0] ss_offset_q,
   output logic therm_shdn_q
);
   import ccs_pkg::*;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   ccs_state_t state_q;
   logic kick_seen_q;
   logic ce_prev_q;
   logic new_cyc;
   logic absent_evt;
   logic factory_on;
   logic [3:0] ichg_tgt;

   ccs_tmr_if deg_if ();
   ccs_tmr_if det_if ();
   ccs_tmr_if syn_if ();
   ccs_tmr_if ret_if ();
   ccs_tmr_if ss_if ();
   ccs_tmr_if slw_if ();

   // Every interval is counted on ref_clk and frozen in thermal shutdown
   ccs_timer #(.COUNT(T_DEGLITCH), .AUTO(1'b0)) u_deg (.clk(ref_clk), .rst(sys_rst), .t(deg_if.timer));
   ccs_timer #(.COUNT(T_DETECT), .AUTO(1'b0)) u_det (.clk(ref_clk), .rst(sys_rst), .t(det_if.timer));
   ccs_timer #(.COUNT(T_SYNC), .AUTO(1'b0)) u_syn (.clk(ref_clk), .rst(sys_rst), .t(syn_if.timer));
   ccs_timer #(.COUNT(T_RETRY), .AUTO(1'b0)) u_ret (.clk(ref_clk), .rst(sys_rst), .t(ret_if.timer));
   ccs_timer #(.COUNT(T_SS_STEP), .AUTO(1'b1)) u_ss (.clk(ref_clk), .rst(sys_rst), .t(ss_if.timer));
   ccs_timer #(.COUNT(T_SLEW), .AUTO(1'b1)) u_slw (.clk(ref_clk), .rst(sys_rst), .t(slw_if.timer));

   assign deg_if.freeze = therm_shdn_q;
   assign det_if.freeze = therm_shdn_q;
   assign syn_if.freeze = therm_shdn_q;
   assign ret_if.freeze = therm_shdn_q;
   assign ss_if.freeze = therm_shdn_q;
   assign slw_if.freeze = therm_shdn_q;

   // Deglitch runs only while termination is allowed and the battery sits above recharge
   assign deg_if.run = (state_q == ST_CHARGE) && host_mode_q && termination_enable_bit
      && batt_above_rch;
   assign det_if.run = (state_q == ST_DETECT);
   assign syn_if.run = (state_q == ST_SYNC);
   assign ret_if.run = (state_q == ST_RETRY);
   assign ss_if.run = spread_enable_bit;
   assign slw_if.run = (state_q == ST_CHARGE);

   // Re-enable after a disable, a reset request, or input power-on with a low battery
   assign new_cyc = (ce_prev_q && !charge_disable_bit) || reset_bit
      || (por_event && batt_below_lowv);
   assign absent_evt = (state_q == ST_DETECT) && det_if.done && !batt_above_rch
      && !therm_shdn_q && !charge_disable_bit && !new_cyc;
   assign factory_on = factory_mode_bit && no_battery;
   assign ichg_tgt = host_mode_q ? host_ichg_code : `CCS_ICHG_DEF;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ce_prev_q <= 1'b0;
      end else begin
         ce_prev_q <= charge_disable_bit;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= ST_CHARGE;
      end else if (therm_shdn_q) begin
         state_q <= state_q;
      end else if (charge_disable_bit) begin
         state_q <= ST_IDLE;
      end else if (new_cyc) begin
         state_q <= ST_CHARGE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_CHARGE;
            end
            ST_CHARGE: begin
               if (deg_if.done && term_current_det) begin
                  state_q <= ST_DETECT;
               end
            end
            ST_DETECT: begin
               if (det_if.done) begin
                  state_q <= batt_above_rch ? ST_SYNC : ST_RETRY;
               end
            end
            ST_SYNC: begin
               if (syn_if.done) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (!batt_above_rch) begin
                  state_q <= ST_CHARGE;
               end
            end
            ST_RETRY: begin
               if (ret_if.done) begin
                  state_q <= ST_CHARGE;
               end
            end
            default: begin
               state_q <= ST_CHARGE;
            end
         endcase
      end
   end

   // Kicks seen before the input power-on decide the mode taken at it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         kick_seen_q <= 1'b0;
      end else if (watchdog_kick_bit) begin
         kick_seen_q <= 1'b1;
      end else if (por_event) begin
         kick_seen_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         host_mode_q <= 1'b0;
      end else if (absent_evt) begin
         host_mode_q <= 1'b0;
      end else if (i2c_txn) begin
         host_mode_q <= 1'b1;
      end else if (por_event) begin
         host_mode_q <= kick_seen_q || watchdog_kick_bit;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         batt_absent_q <= 1'b0;
      end else if (absent_evt) begin
         batt_absent_q <= 1'b1;
      end else if (state_q == ST_DETECT && det_if.done && batt_above_rch) begin
         batt_absent_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         therm_shdn_q <= 1'b0;
      end else if (over_temp) begin
         therm_shdn_q <= 1'b1;
      end else if (temp_recovered) begin
         therm_shdn_q <= 1'b0;
      end
   end

   // Settings seen by the power stage: pin-selected input limit and default regulation code unless in host mode
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         iin_limit_q <= IIN_100;
         vreg_code_q <= `CCS_VREG_DEF;
      end else if (!host_mode_q) begin
         iin_limit_q <= limit_select_pin ? IIN_500 : IIN_100;
         vreg_code_q <= `CCS_VREG_DEF;
      end else begin
         iin_limit_q <= host_iin_limit;
         vreg_code_q <= (host_vreg_code > `CCS_VREG_MAX) ? `CCS_VREG_MAX : host_vreg_code;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ichg_amp_en_q <= 1'b1;
         hs_limit_x2_q <= 1'b0;
         continuous_conduction_q <= 1'b0;
      end else begin
         ichg_amp_en_q <= !factory_on;
         hs_limit_x2_q <= factory_on;
         continuous_conduction_q <= factory_on;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pwm_en_q <= 1'b0;
         detect_sink_q <= 1'b0;
      end else begin
         pwm_en_q <= (state_q == ST_CHARGE) && !therm_shdn_q;
         detect_sink_q <= (state_q == ST_DETECT) && !therm_shdn_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sync_rect_q <= 1'b0;
      end else begin
         sync_rect_q <= pwm_en_q && (factory_on || lowside_above_thr);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         duty_q <= 8'h00;
      end else if (!pwm_en_q) begin
         duty_q <= 8'h00;
      end else begin
         duty_q <= (duty_req > `CCS_DUTY_MAX) ? `CCS_DUTY_MAX : duty_req;
      end
   end

   // Fast-charge current walks up one code per slew tick to its target and drops to a lower target at once
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         chg_current_q <= 4'h0;
         short_mode_q <= 1'b0;
         cv_taper_q <= 1'b0;
      end else begin
         short_mode_q <= batt_below_short;
         cv_taper_q <= batt_at_vreg && !batt_below_short;
         if (state_q != ST_CHARGE || new_cyc || batt_below_short) begin
            chg_current_q <= 4'h0;
         end else if (chg_current_q > ichg_tgt) begin
            chg_current_q <= ichg_tgt;
         end else if (slw_if.done && !therm_shdn_q && !batt_at_vreg && chg_current_q < ichg_tgt) begin
            chg_current_q <= chg_current_q + 4'h1;
         end
      end
   end

   // Status pin pulls low in every state but done and idle, retry included, and releases on completion
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         charge_done_q <= 1'b0;
         stat_o_q <= 1'b0;
         stat_oe_q <= 1'b0;
      end else begin
         charge_done_q <= (state_q == ST_DONE);
         stat_o_q <= 1'b0;
         stat_oe_q <= (state_q != ST_DONE) && (state_q != ST_IDLE);
      end
   end

   ccs_spread #(.STEPS(`CCS_SS_STEPS)) u_spread (
      .clk(ref_clk),
      .rst(sys_rst),
      .en(spread_enable_bit && pwm_en_q),
      .step(ss_if.done && !therm_shdn_q),
      .offset_q(ss_offset_q)
   );

   property p_short;
      batt_below_short |=> short_mode_q && (chg_current_q == 4'h0);
   endproperty
   a_short: assert property (p_short) else $error("short current not applied");

   property p_detect;
      ($past(state_q) == ST_DETECT) && !$past(therm_shdn_q) |-> detect_sink_q && !pwm_en_q;
   endproperty
   a_detect: assert property (p_detect) else $error("detect sink or pwm wrong");

   property p_absent;
      absent_evt |=> (state_q == ST_RETRY) && !host_mode_q ##1 batt_absent_q;
   endproperty
   a_absent: assert property (p_absent) else $error("absent battery not handled");

   property p_default;
      !host_mode_q && !i2c_txn && !por_event |=> !host_mode_q;
   endproperty
   a_default: assert property (p_default) else $error("left default mode without host");

   property p_kick;
      por_event && !i2c_txn && !absent_evt && !watchdog_kick_bit && !kick_seen_q |=> !host_mode_q;
   endproperty
   a_kick: assert property (p_kick) else $error("host mode kept without kicks");

   property p_iin;
      !host_mode_q && limit_select_pin |=> iin_limit_q == IIN_500;
   endproperty
   a_iin: assert property (p_iin) else $error("default input limit wrong");

   property p_factory;
      factory_mode_bit && no_battery |=> hs_limit_x2_q && continuous_conduction_q && !ichg_amp_en_q;
   endproperty
   a_factory: assert property (p_factory) else $error("factory mode not applied");

   property p_sync;
      !lowside_above_thr && !factory_on |=> !sync_rect_q;
   endproperty
   a_sync: assert property (p_sync) else $error("synchronous below threshold");

   property p_duty;
      pwm_en_q && (duty_req > `CCS_DUTY_MAX) |=> duty_q == `CCS_DUTY_MAX;
   endproperty
   a_duty: assert property (p_duty) else $error("duty not clamped");

   property p_vreg;
      !host_mode_q |=> vreg_code_q == `CCS_VREG_DEF;
   endproperty
   a_vreg: assert property (p_vreg) else $error("default regulation voltage wrong");

   property p_qualify;
      (state_q == ST_DETECT) && ($past(state_q) == ST_CHARGE) |-> $past(deg_if.done && term_current_det);
   endproperty
   a_qualify: assert property (p_qualify) else $error("termination not qualified");

   property p_done;
      $rose(charge_done_q) |-> ($past(state_q, 2) == ST_SYNC);
   endproperty
   a_done: assert property (p_done) else $error("completion before sync delay");

   property p_recharge;
      (state_q == ST_DONE) && !batt_above_rch && !charge_disable_bit && !therm_shdn_q |=> state_q == ST_CHARGE;
   endproperty
   a_recharge: assert property (p_recharge) else $error("recharge not started");

   property p_therm;
      therm_shdn_q |=> $stable(state_q) && !pwm_en_q;
   endproperty
   a_therm: assert property (p_therm) else $error("thermal shutdown not honoured");
endmodule

// ===== shared/ccs_regs.svh
// Purpose: constants of the charger control sequencer
// Assumes: included by bare name
// Notes: times are in their printed units, counts derive from the clock
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
`define CCS_CLK_KHZ 25000
`define CCS_T_DEGLITCH_MS 32
`define CCS_T_DETECT_MS 262
`define CCS_T_SYNC_MS 40
`define CCS_T_RETRY_MS 100
`define CCS_T_SS_STEP_US 170
`define CCS_T_SLEW_US 100
`define CCS_SS_STEPS 8
`define CCS_VREG_DEF 6'h02
`define CCS_VREG_MAX 6'h2F
`define CCS_ICHG_DEF 4'h0
`define CCS_DUTY_MAX 8'hC7
`endif

// ===== shared/ccs_pkg.sv
// Purpose: types of the charger control sequencer
// Assumes: nothing
// Notes: state codes are one-hot
package ccs_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CHARGE = 6'h02,
      ST_DETECT = 6'h04,
      ST_SYNC = 6'h08,
      ST_DONE = 6'h10,
      ST_RETRY = 6'h20
   } ccs_state_t;
   typedef enum logic [1:0] {
      IIN_100 = 2'h0,
      IIN_500 = 2'h1,
      IIN_800 = 2'h2,
      IIN_NONE = 2'h3
   } ccs_iin_t;
endpackage

// ===== shared/ccs_tmr_if.sv
// Purpose: control and result of one interval timer
// Assumes: one owner, one timer
// Notes: run low clears the timer unless frozen
`timescale 1ns/1ps
interface ccs_tmr_if;
   logic run;
   logic freeze;
   logic done;
   modport owner (output run, output freeze, input done);
   modport timer (input run, input freeze, output done);
endinterface

// ===== rtl/ccs_timer.sv
// Purpose: interval counter on the reference clock
// Assumes: COUNT of at least 2
// Notes: one-shot holds done, AUTO pulses done every COUNT cycles
`timescale 1ns/1ps
module ccs_timer #(
   parameter int COUNT = 16,
   parameter bit AUTO = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   ccs_tmr_if.timer t
);
   localparam int W = (COUNT > 2) ? $clog2(COUNT) : 1;
   logic [W-1:0] cnt_q;
   logic hit;
   assign hit = (cnt_q == W'(COUNT - 1));
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         t.done <= 1'b0;
      end else if (!t.freeze) begin
         if (!t.run) begin
            cnt_q <= '0;
            t.done <= 1'b0;
         end else if (hit) begin
            t.done <= 1'b1;
            if (AUTO) begin
               cnt_q <= '0;
            end
         end else begin
            cnt_q <= cnt_q + 1'b1;
            t.done <= 1'b0;
         end
      end
   end
endmodule

// ===== rtl/ccs_spread.sv
// Purpose: spread-spectrum offset stepper
// Assumes: step is a one-cycle pulse
// Notes: offsets in units of an eighth of the full swing, half above and half below
`timescale 1ns/1ps
module ccs_spread #(
   parameter int STEPS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en,
   input wire logic step,
   output logic [3:0] offset_q
);
   localparam int W = $clog2(STEPS);
   localparam int HALF = STEPS / 2;
   logic [W-1:0] idx_q;
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         idx_q <= '0;
      end else if (step) begin
         idx_q <= idx_q + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !en) begin
         offset_q <= 4'h0;
      end else if (idx_q < W'(HALF)) begin
         offset_q <= 4'(idx_q) + 4'h1;
      end else begin
         offset_q <= 4'h0 - (4'(idx_q) - 4'(HALF) + 4'h1);
      end
   end
endmodule

// ===== verif/ccs_batt_model.sv
// Purpose: battery pack and power-stage comparators facing the sequencer
// Assumes: the bench decides whether a pack is fitted and whether it is full
// Notes: an absent pack collapses under the detect sink
`timescale 1ns/1ps
module ccs_batt_model (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic present,
   input wire logic full,
   input wire logic deep,
   input wire logic pwm_en,
   input wire logic detect_sink,
   output logic batt_below_short,
   output logic batt_above_rch,
   output logic batt_below_lowv,
   output logic batt_at_vreg,
   output logic term_current_det,
   output logic no_battery
);
   logic sagged_q;
   // Without a pack only the output capacitor holds the voltage up
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !detect_sink) begin
         sagged_q <= 1'b0;
      end else if (!present) begin
         sagged_q <= 1'b1;
      end
   end
   assign batt_above_rch = full && !sagged_q;
   assign batt_at_vreg = full;
   assign term_current_det = full && pwm_en;
   assign batt_below_lowv = !full;
   assign batt_below_short = deep;
   assign no_battery = !present;
endmodule

// ===== verif/ccs_top_bench.sv
// Purpose: self-checking bench of the charger control sequencer
// Assumes: shortened interval parameters
// Notes: random duty and voltage codes from a fixed seed
`timescale 1ns/1ps
`include "ccs_regs.svh"
module ccs_top_bench;
   import ccs_pkg::*;
   localparam int TDG = 20;
   localparam int TDT = 30;
   localparam int TSY = 10;
   localparam int TRT = 15;
   localparam int TSS = 5;
   localparam int TSL = 4;
   logic ref_clk, sys_rst, por_event, i2c_txn, watchdog_kick_bit, termination_enable_bit;
   logic charge_disable_bit, reset_bit, factory_mode_bit, spread_enable_bit, limit_select_pin;
   logic lowside_above_thr, over_temp, temp_recovered, present, full, deep;
   logic batt_below_short, batt_above_rch, batt_below_lowv, batt_at_vreg, term_current_det, no_battery;
   ccs_iin_t host_iin_limit, iin_limit_q;
   logic [5:0] host_vreg_code, vreg_code_q;
   logic [3:0] host_ichg_code, chg_current_q, ss_offset_q;
   logic [7:0] duty_req, duty_q;
   logic host_mode_q, pwm_en_q, short_mode_q, cv_taper_q, detect_sink_q, charge_done_q, batt_absent_q;
   logic stat_o_q, stat_oe_q, ichg_amp_en_q, hs_limit_x2_q, continuous_conduction_q, sync_rect_q, therm_shdn_q;
   int errors = 0;
   int comparisons = 0;
   int seed = 24106;
   int n, pos, neg;
   logic [3:0] v;

   ccs_top #(.T_DEGLITCH(TDG), .T_DETECT(TDT), .T_SYNC(TSY), .T_RETRY(TRT), .T_SS_STEP(TSS),
      .T_SLEW(TSL)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_event(por_event), .i2c_txn(i2c_txn),
      .watchdog_kick_bit(watchdog_kick_bit), .termination_enable_bit(termination_enable_bit),
      .charge_disable_bit(charge_disable_bit), .reset_bit(reset_bit), .factory_mode_bit(factory_mode_bit),
      .spread_enable_bit(spread_enable_bit), .limit_select_pin(limit_select_pin),
      .host_iin_limit(host_iin_limit), .host_vreg_code(host_vreg_code), .host_ichg_code(host_ichg_code),
      .batt_below_short(batt_below_short), .batt_above_rch(batt_above_rch), .batt_below_lowv(batt_below_lowv),
      .batt_at_vreg(batt_at_vreg), .term_current_det(term_current_det), .lowside_above_thr(lowside_above_thr),
      .no_battery(no_battery), .over_temp(over_temp), .temp_recovered(temp_recovered), .duty_req(duty_req),
      .host_mode_q(host_mode_q), .pwm_en_q(pwm_en_q), .short_mode_q(short_mode_q), .cv_taper_q(cv_taper_q),
      .chg_current_q(chg_current_q), .detect_sink_q(detect_sink_q), .charge_done_q(charge_done_q),
      .batt_absent_q(batt_absent_q), .stat_o_q(stat_o_q), .stat_oe_q(stat_oe_q), .iin_limit_q(iin_limit_q),
      .vreg_code_q(vreg_code_q), .ichg_amp_en_q(ichg_amp_en_q), .hs_limit_x2_q(hs_limit_x2_q),
      .continuous_conduction_q(continuous_conduction_q), .sync_rect_q(sync_rect_q), .duty_q(duty_q),
      .ss_offset_q(ss_offset_q), .therm_shdn_q(therm_shdn_q));
   ccs_batt_model batt_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .present(present), .full(full),
      .deep(deep), .pwm_en(pwm_en_q), .detect_sink(detect_sink_q), .batt_below_short(batt_below_short),
      .batt_above_rch(batt_above_rch), .batt_below_lowv(batt_below_lowv), .batt_at_vreg(batt_at_vreg),
      .term_current_det(term_current_det), .no_battery(no_battery));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] clamp_duty(input logic [7:0] r);
      return (r > `CCS_DUTY_MAX) ? `CCS_DUTY_MAX : r;
   endfunction

   task summarize();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      errors++;
      summarize();
   end

   initial begin
      {por_event, i2c_txn, watchdog_kick_bit, charge_disable_bit, reset_bit, factory_mode_bit} = '0;
      {spread_enable_bit, limit_select_pin, lowside_above_thr, over_temp, temp_recovered, deep} = '0;
      {present, full, termination_enable_bit} = 3'b101;
      host_iin_limit = IIN_100;
      host_vreg_code = 6'h00;
      host_ichg_code = 4'h3;
      duty_req = 8'h00;
      sys_rst = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      tick(3);
      chk(host_mode_q, 1'b0);
      chk(vreg_code_q, `CCS_VREG_DEF);
      chk(iin_limit_q, IIN_100);
      limit_select_pin = 1'b1;
      tick(2);
      chk(iin_limit_q, IIN_500);
      chk(chg_current_q, `CCS_ICHG_DEF);
      $display("default mode test done");
      i2c_txn = 1'b1;
      tick(1);
      i2c_txn = 1'b0;
      tick(2);
      chk(host_mode_q, 1'b1);
      for (int c = 0; c < 4; c++) begin
         host_iin_limit = ccs_iin_t'(c);
         tick(2);
         chk(iin_limit_q, c);
      end
      for (int k = 0; k < 6; k++) begin
         host_vreg_code = (k == 0) ? 6'h3F : 6'($random(seed));
         tick(2);
         chk(vreg_code_q, (host_vreg_code > `CCS_VREG_MAX) ? `CCS_VREG_MAX : host_vreg_code);
      end
      tick(3 * TSL + 4);
      chk(chg_current_q, host_ichg_code);
      reset_bit = 1'b1;
      tick(1);
      reset_bit = 1'b0;
      chk(chg_current_q, 4'h0);
      deep = 1'b1;
      tick(3);
      chk({short_mode_q, chg_current_q}, 5'h10);
      deep = 1'b0;
      for (int k = 0; k < 10; k++) begin
         duty_req = (k < 3) ? 8'hC7 + 8'(k) : 8'($random(seed));
         lowside_above_thr = k[0];
         tick(3);
         chk(duty_q, clamp_duty(duty_req));
         chk(sync_rect_q, lowside_above_thr);
      end
      $display("host settings test done");
      spread_enable_bit = 1'b1;
      pos = 0;
      neg = 0;
      for (int i = 0; i < 9; i++) begin
         v = ss_offset_q;
         n = 0;
         while (ss_offset_q === v && n < 4 * TSS) begin
            tick(1);
            n++;
         end
         // The first offset also stands through the enable cycle
         if (i > 0) chk(n, (i == 1) ? TSS + 1 : TSS);
         if (i > 0 && !ss_offset_q[3] && ss_offset_q != 4'h0 && ss_offset_q <= 4'h4) pos++;
         if (i > 0 && ss_offset_q[3] && ss_offset_q >= 4'hC) neg++;
      end
      chk({pos[7:0], neg[7:0]}, 16'h0404);
      spread_enable_bit = 1'b0;
      $display("spread test done");
      over_temp = 1'b1;
      tick(4);
      chk({therm_shdn_q, pwm_en_q, duty_q}, 10'h200);
      over_temp = 1'b0;
      temp_recovered = 1'b1;
      tick(4);
      temp_recovered = 1'b0;
      chk({therm_shdn_q, pwm_en_q}, 2'b01);
      termination_enable_bit = 1'b0;
      full = 1'b1;
      tick(TDG + TDT);
      chk(detect_sink_q, 1'b0);
      chk(cv_taper_q, 1'b1);
      termination_enable_bit = 1'b1;
      n = 0;
      while (detect_sink_q !== 1'b1 && n < TDG + 10) begin
         tick(1);
         n++;
      end
      chk(n >= TDG && n < TDG + 10, 1'b1);
      chk({pwm_en_q, charge_done_q}, 2'b00);
      n = 0;
      while (charge_done_q !== 1'b1 && n < TDT + TSY + 10) begin
         tick(1);
         n++;
      end
      chk(n >= TDT + TSY && n < TDT + TSY + 8, 1'b1);
      chk({stat_o_q, stat_oe_q, batt_absent_q}, 3'b000);
      full = 1'b0;
      tick(4);
      chk(charge_done_q, 1'b0);
      chk({stat_o_q, stat_oe_q}, 2'b01);
      $display("termination test done");
      present = 1'b0;
      full = 1'b1;
      limit_select_pin = 1'b0;
      n = 0;
      while (batt_absent_q !== 1'b1 && n < TDG + TDT + 20) begin
         tick(1);
         n++;
      end
      full = 1'b0;
      // Settings follow host mode one cycle after the absent decision
      tick(1);
      chk({host_mode_q, batt_absent_q, iin_limit_q}, {2'b01, IIN_100});
      chk(vreg_code_q, `CCS_VREG_DEF);
      chk(pwm_en_q, 1'b0);
      tick(TRT + 5);
      chk(pwm_en_q, 1'b1);
      factory_mode_bit = 1'b1;
      tick(3);
      chk({ichg_amp_en_q, hs_limit_x2_q, continuous_conduction_q}, 3'b011);
      present = 1'b1;
      tick(3);
      chk({ichg_amp_en_q, hs_limit_x2_q, continuous_conduction_q}, 3'b100);
      factory_mode_bit = 1'b0;
      $display("absent and factory test done");
      watchdog_kick_bit = 1'b1;
      tick(1);
      watchdog_kick_bit = 1'b0;
      tick(2);
      por_event = 1'b1;
      tick(1);
      por_event = 1'b0;
      tick(2);
      chk(host_mode_q, 1'b1);
      por_event = 1'b1;
      tick(1);
      por_event = 1'b0;
      tick(2);
      chk(host_mode_q, 1'b0);
      charge_disable_bit = 1'b1;
      tick(3);
      chk(pwm_en_q, 1'b0);
      charge_disable_bit = 1'b0;
      tick(3);
      chk(pwm_en_q, 1'b1);
      $display("power-on and restart test done");
      summarize();
   end
endmodule
